// *** dv/selftest_partner.sv ***
// Behavioural self-test engine answering one start request of the handler.
// Assumes start is a level that rises once for every self-test run.
`default_nettype none
module selftest_partner #(
  parameter int DELAY = 20
) (
  input wire logic clk,
  input wire logic start,
  input wire logic ok,
  output logic done,
  output logic pass
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_q = 1'b0;
  int cnt_q = 0;

  // The result line shows the opposite of the verdict outside the done pulse.
  always_ff @(posedge clk) begin
    prev_q <= start;
    done <= 1'b0;
    pass <= !ok;
    if (start && !prev_q) begin
      cnt_q <= DELAY;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end
    if (cnt_q == 1 && start) begin
      done <= 1'b1;
      pass <= ok;
    end
  end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the safety fault handler.
// Assumes the handler, its package and the self-test partner model.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ch_fault = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0, rdata, info_a = 16'h0, info_b = 16'h0;
  logic [15:0] ch_info = 16'h0, d;
  logic [7:0] cpu_fault = 8'h0, safe_out;
  logic [2:0] ch_id = 3'h0;
  logic memchk_done = 1'b0, memchk_en = 1'b1, app_present = 1'b1;
  logic post_done, post_pass, post_start, cpu_run, cpu_error, mod_fault = 1'b0;
  logic mod_post_done, mod_post_pass, mod_post_start, mod_reset;
  logic cpu_ok = 1'b1, mod_ok = 1'b1;
  int n_errors = 0, samples_checked = 0;
  logic [15:0] codes [8] = '{fault_pkg::CODE_SEQ, fault_pkg::CODE_ADDR,
    fault_pkg::CODE_CMP, fault_pkg::CODE_RTC, fault_pkg::CODE_DUAL,
    fault_pkg::CODE_WDOG, fault_pkg::CODE_MTIME, fault_pkg::CODE_RAM};

  safety_fault_handler #(.MEMCHK_CYCLES(1000)) safety_fault_handler_i (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CPU_FAULT(cpu_fault), .FAULT_INFO_A(info_a),
    .FAULT_INFO_B(info_b), .MEMCHK_DONE(memchk_done),
    .APP_PRESENT(app_present), .POST_DONE(post_done), .POST_PASS(post_pass),
    .POST_START(post_start), .CPU_RUN(cpu_run), .CPU_ERROR(cpu_error),
    .CH_FAULT(ch_fault), .CH_FAULT_ID(ch_id), .CH_FAULT_INFO(ch_info),
    .MOD_FAULT(mod_fault), .MOD_POST_DONE(mod_post_done),
    .MOD_POST_PASS(mod_post_pass), .MOD_POST_START(mod_post_start),
    .MOD_RESET(mod_reset), .SAFE_OUT(safe_out));
  selftest_partner cpu_test_i (.clk(clk), .start(post_start), .ok(cpu_ok),
    .done(post_done), .pass(post_pass));
  selftest_partner mod_test_i (.clk(clk), .start(mod_post_start),
    .ok(mod_ok), .done(mod_post_done), .pass(mod_post_pass));

  always #5 clk = ~clk;
  // Background memory check finishes well inside the shortened limit.
  always begin
    repeat (400) @(posedge clk);
    memchk_done <= memchk_en;
    @(posedge clk);
    memchk_done <= 1'b0;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] sel);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    wdata <= sel;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic boot(input logic [15:0] ctrl, input logic run);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk({post_start, cpu_run}, 16'h2, "self-test first");
    wr_reg(fault_pkg::REG_CTRL, ctrl);
    wr_reg(fault_pkg::REG_OUT_CMD, 16'h00ff);
    for (int i = 0; i < 300 && cpu_run !== 1'b1; i++) @(posedge clk);
    for (int i = 0; i < 100 && safe_out !== 8'hff; i++) @(posedge clk);
    chk(cpu_run, run, "run state");
    if (run) chk(safe_out, 8'hff, "outputs after start");
  endtask

  task automatic t_causes();
    for (int i = 0; i < 8; i++) begin
      info_a <= 16'h1100 + 16'(i);
      info_b <= 16'h2200 + 16'(i);
      boot(16'h0002, 1'b1);
      @(posedge clk);
      cpu_fault <= 8'h01 << i;
      @(posedge clk);
      cpu_fault <= 8'h00;
      info_a <= 16'h0bad;
      #1 chk({cpu_error, safe_out}, 16'h0100, "error, safe");
      @(posedge clk);
      cpu_fault <= 8'h01 << ((i + 1) % 8);
      @(posedge clk);
      cpu_fault <= 8'h00;
      wr_reg(fault_pkg::REG_OUT_CMD, 16'h00ff);
      wr_reg(fault_pkg::REG_CAUSE, 16'h0000);
      rd_reg(fault_pkg::REG_CAUSE, 16'h0);
      chk(d, codes[i], "cause code");
      rd_reg(fault_pkg::REG_DETAIL_A, 16'h0);
      chk(d, 16'h1100 + 16'(i), "detail a");
      rd_reg(fault_pkg::REG_DETAIL_B, 16'h0);
      chk(d, 16'h2200 + 16'(i), "detail b");
      chk({cpu_error, safe_out}, 16'h0100, "error held");
    end
  endtask

  task automatic t_memchk();
    memchk_en <= 1'b0;
    boot(16'h0002, 1'b1);
    repeat (1100) @(posedge clk);
    memchk_en <= 1'b1;
    rd_reg(fault_pkg::REG_CAUSE, 16'h0);
    chk(d, fault_pkg::CODE_MTIME, "check overrun");
    chk({cpu_error, safe_out}, 16'h0100, "overrun safe");
  endtask

  task automatic t_start_cases();
    app_present <= 1'b0;
    boot(16'h0001, 1'b0);
    app_present <= 1'b1;
    boot(16'h0001, 1'b1);
    cpu_fault <= 8'h01;
    boot(16'h0001, 1'b0);
    chk(cpu_error, 1'b1, "persistent fault");
    cpu_fault <= 8'h00;
    cpu_ok <= 1'b0;
    boot(16'h0001, 1'b0);
    chk(cpu_error, 1'b1, "failed self-test");
    cpu_ok <= 1'b1;
  endtask

  task automatic t_channel();
    boot(16'h0002, 1'b1);
    @(posedge clk);
    ch_id <= 3'h5;
    ch_info <= 16'hc0de;
    ch_fault <= 1'b1;
    @(posedge clk);
    ch_fault <= 1'b0;
    @(posedge clk);
    #1 chk(safe_out, 8'hdf, "one channel safe");
    rd_reg(fault_pkg::REG_CH_FAULT, 16'h0);
    chk(d, 16'h0020, "channel flags");
    rd_reg(fault_pkg::REG_CH_DETAIL, 16'h0005);
    chk(d, 16'hc0de, "channel detail");
    rd_reg(4'hf, 16'h0);
    chk(d, 16'h0000, "unmapped read");
  endtask

  task automatic t_module();
    boot(16'h0002, 1'b1);
    mod_ok <= 1'b0;
    @(posedge clk);
    mod_fault <= 1'b1;
    @(posedge clk);
    mod_fault <= 1'b0;
    #1 chk(safe_out, 8'h00, "module safe");
    for (int i = 0; i < 50 && mod_reset !== 1'b1; i++) @(posedge clk);
    chk(mod_reset, 1'b1, "module reset");
    for (int i = 0; i < 100 && mod_post_start !== 1'b1; i++) @(posedge clk);
    chk(mod_post_start, 1'b1, "module self-test");
    for (int i = 0; i < 100 && mod_reset !== 1'b1; i++) @(posedge clk);
    chk({mod_reset, safe_out}, 16'h0100, "reset again");
    mod_ok <= 1'b1;
    for (int i = 0; i < 300 && safe_out !== 8'hff; i++) @(posedge clk);
    chk(safe_out, 8'hff, "outputs back on");
    rd_reg(fault_pkg::REG_RESTARTS, 16'h0);
    chk(d, 16'h0002, "restart count");
    rd_reg(fault_pkg::REG_STATUS, 16'h0);
    chk(d, 16'h0032, "module and cpu state");
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    conclude();
  end

  initial begin
    t_causes();
    t_memchk();
    t_start_cases();
    t_channel();
    t_module();
    conclude();
  end
endmodule
`default_nettype wire

// *** include/fault_pkg.sv ***
// Shared constants for the safety fault handler.
// Assumes a 100 MHz clock and a plain register port with word indices.
`default_nettype none
package fault_pkg;
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_SEQ = 16'h5af1;
  localparam logic [15:0] CODE_ADDR = 16'h5af2;
  localparam logic [15:0] CODE_CMP = 16'h5af3;
  localparam logic [15:0] CODE_RTC = 16'h5af4;
  localparam logic [15:0] CODE_DUAL = 16'h5af5;
  localparam logic [15:0] CODE_WDOG = 16'h5af6;
  localparam logic [15:0] CODE_MTIME = 16'h5af7;
  localparam logic [15:0] CODE_RAM = 16'h5af8;
  localparam int NUM_CAUSES = 8;
  localparam logic [3:0] REG_CAUSE = 4'h0;
  localparam logic [3:0] REG_DETAIL_A = 4'h1;
  localparam logic [3:0] REG_DETAIL_B = 4'h2;
  localparam logic [3:0] REG_CTRL = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_OUT_CMD = 4'h5;
  localparam logic [3:0] REG_CH_FAULT = 4'h6;
  localparam logic [3:0] REG_CH_DETAIL = 4'h7;
  localparam logic [3:0] REG_RESTARTS = 4'h8;
  localparam int CTRL_AUTORUN = 0;
  localparam int CTRL_RUN_REQ = 1;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam longint MEMCHK_LIMIT_HOURS = 8;
  localparam longint CLK_HZ = 100000000;
  localparam longint MEMCHK_LIMIT_CYCLES = MEMCHK_LIMIT_HOURS * 3600 * CLK_HZ;
  localparam int MOD_RESET_CYCLES = 16;
endpackage
`default_nettype wire

// *** rtl/detail_mem.sv ***
// Small register file holding per-channel fault detail words.
// Assumes one write and one registered read per cycle on the same clock.
`default_nettype none
module detail_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// *** rtl/safety_fault_handler.sv ***
// Fault reaction for a safety controller and one safety I/O module.
// Assumes power-up reset on RST, fault pulses from synchronous logic and
// self-test results supplied by the surrounding diagnostics.
//
// Function
// - Any failed check latches error (during self-test only one present at POST_DONE), outputs safe
// - Codes 5AF1 to 5AF4 for listed causes
// - Codes 5AF5, 5AF6, 5AF8 for listed causes
// - Memory check over eight hours gives 5AF7
// - Two detail words kept beside cause
// - Power-up self-test runs before the controller can stop or run; module reset starts alongside
// - Autorun with persisting fault re-enters error
// - No stored application means no run
// - Faulty channel alone goes safe
// - Channel fault flags and details readable in REG_CH_FAULT and REG_CH_DETAIL
// - Module fault: all safe, reset, self-test
// - Failed self-test repeats reset sequence
// - Passed self-test resumes commanded outputs
// - Hot-swapped module self-tests then runs
`default_nettype none
module safety_fault_handler #(
  parameter int CHANNELS = 8,
  parameter int CW = 3,
  parameter longint MEMCHK_CYCLES = fault_pkg::MEMCHK_LIMIT_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic [7:0] CPU_FAULT,
  input wire logic [15:0] FAULT_INFO_A,
  input wire logic [15:0] FAULT_INFO_B,
  input wire logic MEMCHK_DONE,
  input wire logic APP_PRESENT,
  input wire logic POST_DONE,
  input wire logic POST_PASS,
  output logic POST_START,
  output logic CPU_RUN,
  output logic CPU_ERROR,
  input wire logic CH_FAULT,
  input wire logic [CW-1:0] CH_FAULT_ID,
  input wire logic [15:0] CH_FAULT_INFO,
  input wire logic MOD_FAULT,
  input wire logic MOD_POST_DONE,
  input wire logic MOD_POST_PASS,
  output logic MOD_POST_START,
  output logic MOD_RESET,
  output logic [CHANNELS-1:0] SAFE_OUT
);
  typedef enum logic [1:0] {CPU_POST, CPU_STOP, CPU_RUNNING, CPU_ERR} cpu_t;
  typedef enum logic [1:0] {MOD_SAFE, MOD_RST, MOD_TEST, MOD_OP} mod_t;

  cpu_t cpu_q;
  mod_t mod_q;
  logic [15:0] cause_q, det_a_q, det_b_q, ctrl_q, out_cmd_q, restarts_q;
  logic [CHANNELS-1:0] ch_bad_q;
  logic [63:0] memchk_cnt_q;
  logic [7:0] rst_cnt_q;
  logic [15:0] cause_d;
  logic memchk_late, cpu_fail;
  logic [15:0] ch_det_rdata;
  logic rd_q;
  logic [3:0] raddr_q;

  // Lowest set bit picks the cause code.
  always_comb begin
    cause_d = fault_pkg::CODE_NONE;
    for (int i = fault_pkg::NUM_CAUSES - 1; i >= 0; i--) begin
      if (CPU_FAULT[i] || (i == 6 && memchk_late)) begin
        cause_d = fault_pkg::CODE_SEQ + 16'(i);
      end
    end
  end

  assign memchk_late = (memchk_cnt_q >= 64'(MEMCHK_CYCLES));
  assign cpu_fail = (CPU_FAULT != 8'h00) || memchk_late;

  always_ff @(posedge CLK) begin
    if (RST || MEMCHK_DONE || cpu_q == CPU_ERR) begin
      memchk_cnt_q <= 64'h0;
    end else begin
      memchk_cnt_q <= memchk_cnt_q + 64'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cpu_q <= CPU_POST;
    end else begin
      unique case (cpu_q)
        CPU_POST: begin
          if (POST_DONE) begin
            if (!POST_PASS || cpu_fail) begin
              cpu_q <= CPU_ERR;
            end else if (APP_PRESENT && ctrl_q[fault_pkg::CTRL_AUTORUN]) begin
              cpu_q <= CPU_RUNNING;
            end else begin
              cpu_q <= CPU_STOP;
            end
          end
        end
        CPU_STOP: begin
          if (cpu_fail) begin
            cpu_q <= CPU_ERR;
          end else if (APP_PRESENT && ctrl_q[fault_pkg::CTRL_RUN_REQ]) begin
            cpu_q <= CPU_RUNNING;
          end
        end
        CPU_RUNNING: begin
          if (cpu_fail) begin
            cpu_q <= CPU_ERR;
          end
        end
        CPU_ERR: cpu_q <= CPU_ERR;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cause_q <= fault_pkg::CODE_NONE;
      det_a_q <= 16'h0000;
      det_b_q <= 16'h0000;
    end else if (cpu_q != CPU_ERR && cpu_fail) begin
      cause_q <= cause_d;
      det_a_q <= FAULT_INFO_A;
      det_b_q <= FAULT_INFO_B;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      POST_START <= 1'b0;
      CPU_RUN <= 1'b0;
      CPU_ERROR <= 1'b0;
    end else begin
      POST_START <= (cpu_q == CPU_POST);
      CPU_RUN <= (cpu_q == CPU_RUNNING) && !cpu_fail;
      CPU_ERROR <= (cpu_q == CPU_ERR) || cpu_fail;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      mod_q <= MOD_RST;
      rst_cnt_q <= 8'h00;
      restarts_q <= 16'h0000;
    end else begin
      unique case (mod_q)
        MOD_SAFE: begin
          mod_q <= MOD_RST;
          rst_cnt_q <= 8'h00;
          restarts_q <= restarts_q + 16'h1;
        end
        MOD_RST: begin
          if (rst_cnt_q == 8'(fault_pkg::MOD_RESET_CYCLES - 1)) begin
            mod_q <= MOD_TEST;
          end else begin
            rst_cnt_q <= rst_cnt_q + 8'h1;
          end
        end
        MOD_TEST: begin
          if (MOD_POST_DONE) begin
            mod_q <= MOD_POST_PASS ? MOD_OP : MOD_SAFE;
          end
        end
        MOD_OP: begin
          if (MOD_FAULT) begin
            mod_q <= MOD_SAFE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || mod_q == MOD_RST) begin
      ch_bad_q <= '0;
    end else if (CH_FAULT && mod_q == MOD_OP) begin
      ch_bad_q[CH_FAULT_ID] <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      SAFE_OUT <= '0;
      MOD_RESET <= 1'b0;
      MOD_POST_START <= 1'b0;
    end else begin
      MOD_RESET <= (mod_q == MOD_RST);
      MOD_POST_START <= (mod_q == MOD_TEST);
      for (int c = 0; c < CHANNELS; c++) begin
        SAFE_OUT[c] <= out_cmd_q[c] && !ch_bad_q[c] && mod_q == MOD_OP &&
                       !MOD_FAULT && cpu_q != CPU_ERR && !cpu_fail &&
                       !(CH_FAULT && CH_FAULT_ID == CW'(c));
      end
    end
  end

  detail_mem #(.DEPTH(CHANNELS), .WIDTH(16), .AW(CW)) u_detail (
    .clk(CLK),
    .we(CH_FAULT && mod_q == MOD_OP),
    .waddr(CH_FAULT_ID),
    .wdata(CH_FAULT_INFO),
    .raddr(WDATA[CW-1:0]),
    .rdata(ch_det_rdata)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= fault_pkg::CTRL_RESET;
      out_cmd_q <= 16'h0000;
    end else if (WR) begin
      if (ADDR == fault_pkg::REG_CTRL) begin
        ctrl_q <= WDATA;
      end
      if (ADDR == fault_pkg::REG_OUT_CMD) begin
        out_cmd_q <= WDATA;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rd_q <= 1'b0;
      raddr_q <= 4'h0;
    end else begin
      rd_q <= RD;
      raddr_q <= ADDR;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_comb begin
    RDATA = 16'h0000;
    if (rd_q) begin
      unique case (raddr_q)
        fault_pkg::REG_CAUSE: RDATA = cause_q;
        fault_pkg::REG_DETAIL_A: RDATA = det_a_q;
        fault_pkg::REG_DETAIL_B: RDATA = det_b_q;
        fault_pkg::REG_CTRL: RDATA = ctrl_q;
        fault_pkg::REG_STATUS: RDATA = {10'h000, mod_q, 2'b00, cpu_q};
        fault_pkg::REG_OUT_CMD: RDATA = out_cmd_q;
        fault_pkg::REG_CH_FAULT: RDATA = 16'(ch_bad_q);
        fault_pkg::REG_CH_DETAIL: RDATA = ch_det_rdata;
        fault_pkg::REG_RESTARTS: RDATA = restarts_q;
        default: RDATA = 16'h0000;
      endcase
    end
  end

  property p_err_sticky;
    @(posedge CLK) disable iff (RST) cpu_q == CPU_ERR |=> cpu_q == CPU_ERR;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error state left");

  property p_fail_safe;
    @(posedge CLK) disable iff (RST) cpu_fail |=> SAFE_OUT == '0;
  endproperty
  a_fail_safe: assert property (p_fail_safe)
    else $error("outputs not safe after fault");

  property p_cause_seq;
    @(posedge CLK) disable iff (RST)
      cpu_q == CPU_RUNNING && CPU_FAULT == 8'h01 && !memchk_late
      |=> cause_q == 16'h5af1 && CPU_ERROR;
  endproperty
  a_cause_seq: assert property (p_cause_seq)
    else $error("sequence cause wrong");

  property p_cause_ram;
    @(posedge CLK) disable iff (RST)
      cpu_q == CPU_RUNNING && CPU_FAULT == 8'h80 && !memchk_late
      |=> cause_q == 16'h5af8;
  endproperty
  a_cause_ram: assert property (p_cause_ram)
    else $error("ram cause wrong");

  property p_memchk;
    @(posedge CLK) disable iff (RST)
      cpu_q == CPU_RUNNING && memchk_late && CPU_FAULT == 8'h00
      |=> cause_q == 16'h5af7;
  endproperty
  a_memchk: assert property (p_memchk)
    else $error("memory check timeout cause wrong");

  property p_no_app;
    @(posedge CLK) disable iff (RST)
      !APP_PRESENT && cpu_q != CPU_RUNNING |=> cpu_q != CPU_RUNNING;
  endproperty
  a_no_app: assert property (p_no_app)
    else $error("ran without application");

  sequence s_mod_fault;
    mod_q == MOD_OP && MOD_FAULT;
  endsequence
  sequence s_mod_restart;
    mod_q == MOD_SAFE ##1 mod_q == MOD_RST;
  endsequence
  property p_mod_fault;
    @(posedge CLK) disable iff (RST) s_mod_fault |=> s_mod_restart;
  endproperty
  a_mod_fault: assert property (p_mod_fault)
    else $error("module fault restart missing");

  property p_post_fail;
    @(posedge CLK) disable iff (RST)
      mod_q == MOD_TEST && MOD_POST_DONE && !MOD_POST_PASS
      |=> mod_q == MOD_SAFE ##1 mod_q == MOD_RST;
  endproperty
  a_post_fail: assert property (p_post_fail)
    else $error("failed self-test not retried");

  property p_ch_safe;
    @(posedge CLK) disable iff (RST)
      mod_q == MOD_OP && CH_FAULT |=> !SAFE_OUT[$past(CH_FAULT_ID)];
  endproperty
  a_ch_safe: assert property (p_ch_safe)
    else $error("faulty channel still driven");

  property p_mod_resume;
    @(posedge CLK) disable iff (RST)
      mod_q == MOD_TEST && MOD_POST_DONE && MOD_POST_PASS
      |=> mod_q == MOD_OP;
  endproperty
  a_mod_resume: assert property (p_mod_resume)
    else $error("module did not resume after passed self-test");

  property p_post_first;
    @(posedge CLK) disable iff (RST)
      cpu_q == CPU_POST && !POST_DONE |=> cpu_q == CPU_POST;
  endproperty
  a_post_first: assert property (p_post_first)
    else $error("controller left self-test early");
endmodule
`default_nettype wire
